/* hdl/video_clamp_format_sync_mask.sv */
// video_clamp_format_sync_mask: format mapping, clamp timing, sync masking
// and loop gain registers for a triple-channel video front end.
// assumes: pixel stream and sync inputs synchronous to ref_clk, one
// sample per cycle while pixValid; analog parts sit outside.
`timescale 1ns/1ps
`default_nettype none
module video_clamp_format_sync_mask #(
  parameter int CNT_W      = 16,
  parameter int ACT_WINDOW = 8192
) (
  // clock, reset, enable
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  input  wire logic                       clkEn,
  // axi4-lite slave
  input  wire logic [9:0]                 s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [9:0]                 s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // digitized stream and sync inputs
  input  wire video_front_pkg::pixel_s    pixIn,
  input  wire logic                       pixValid,
  input  wire logic                       hsyncIn,
  input  wire logic                       vsyncIn,
  input  wire logic                       greenSliceIn,
  input  wire logic                       loopCoasting,
  input  wire logic                       copyProtDetect,
  input  wire logic                       copyMaskIn,
  // outputs
  output video_front_pkg::pixel_s         pixOut,
  output logic                            pixOutValid,
  output logic                            clampOn,
  output logic                            blackAvgStart,
  output logic                            dcCoupled,
  output logic                            loopSyncOut,
  output logic                            hsyncOut,
  output logic [7:0]                      loopGain,
  output logic [3:0]                      slicerThreshold,
  output logic [7:0]                      slicerCtrlB,
  output logic                            triLevelSeen
);

  // register file
  logic [7:0] inputCfg_ff, startHi_ff, startLo_ff, width_ff, outFmt_ff;
  logic [7:0] slicerA_ff, slicerB_ff, syncCtrl_ff, gain_ff, hsCtrl_ff;
  video_front_pkg::sync_act_s act_ff;

  function automatic logic [7:0] idx_of(input logic [9:0] a);
    return a[9:2];
  endfunction : idx_of

  // write channel: address and data taken in either order
  logic       awHeld_ff, wHeld_ff;
  logic [7:0] awIdx_ff;
  logic [31:0] wData_ff;
  logic [3:0]  wStrb_ff;
  logic        wrFire;
  logic        wrHit;
  assign wrFire = awHeld_ff && wHeld_ff && !s_axi_bvalid;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awHeld_ff     <= 1'b0;
      wHeld_ff      <= 1'b0;
      awIdx_ff      <= 8'h00;
      wData_ff      <= 32'h0000_0000;
      wStrb_ff      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= video_front_pkg::RESP_OKAY;
    end else if (clkEn) begin
      s_axi_awready <= !awHeld_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !wHeld_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_ff <= 1'b1;
        awIdx_ff  <= idx_of(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld_ff    <= 1'b0;
        wHeld_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? video_front_pkg::RESP_OKAY
                              : video_front_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    wrHit = 1'b1;
    if (awIdx_ff == video_front_pkg::IDX_INPUT_CFG) wrHit = 1'b1;
    else if (awIdx_ff == video_front_pkg::IDX_CLAMP_START_H) wrHit = 1'b1;
    else if (awIdx_ff == video_front_pkg::IDX_CLAMP_START_L) wrHit = 1'b1;
    else if (awIdx_ff == video_front_pkg::IDX_CLAMP_WIDTH) wrHit = 1'b1;
    else if (awIdx_ff == video_front_pkg::IDX_OUT_FORMAT) wrHit = 1'b1;
    else if (awIdx_ff == video_front_pkg::IDX_SLICER_A) wrHit = 1'b1;
    else if (awIdx_ff == video_front_pkg::IDX_SLICER_B) wrHit = 1'b1;
    else if (awIdx_ff == video_front_pkg::IDX_SYNC_CTRL) wrHit = 1'b1;
    else if (awIdx_ff == video_front_pkg::IDX_LOOP_GAIN) wrHit = 1'b1;
    else if (awIdx_ff == video_front_pkg::IDX_HSOUT_CTRL) wrHit = 1'b1;
    else wrHit = 1'b0;
  end

  // only byte lane 0 carries data; upper lanes are ignored
  logic wrLane0;
  assign wrLane0 = wrFire && wStrb_ff[0];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      inputCfg_ff <= video_front_pkg::RST_ZERO;
      startHi_ff  <= video_front_pkg::RST_ZERO;
      startLo_ff  <= video_front_pkg::RST_ZERO;
      width_ff    <= video_front_pkg::RST_ZERO;
      outFmt_ff   <= video_front_pkg::RST_ZERO;
      slicerA_ff  <= video_front_pkg::RST_ZERO;
      slicerB_ff  <= video_front_pkg::RST_ZERO;
      syncCtrl_ff <= video_front_pkg::RST_ZERO;
      gain_ff     <= video_front_pkg::RST_LOOP_GAIN;
      hsCtrl_ff   <= video_front_pkg::RST_ZERO;
    end else if (clkEn && wrLane0) begin
      if (awIdx_ff == video_front_pkg::IDX_INPUT_CFG)
        inputCfg_ff <= wData_ff[7:0];
      else if (awIdx_ff == video_front_pkg::IDX_CLAMP_START_H)
        startHi_ff <= wData_ff[7:0];
      else if (awIdx_ff == video_front_pkg::IDX_CLAMP_START_L)
        startLo_ff <= wData_ff[7:0];
      else if (awIdx_ff == video_front_pkg::IDX_CLAMP_WIDTH)
        width_ff <= wData_ff[7:0];
      else if (awIdx_ff == video_front_pkg::IDX_OUT_FORMAT)
        outFmt_ff <= wData_ff[7:0];
      else if (awIdx_ff == video_front_pkg::IDX_SLICER_A)
        slicerA_ff <= wData_ff[7:0];
      else if (awIdx_ff == video_front_pkg::IDX_SLICER_B)
        slicerB_ff <= wData_ff[7:0];
      else if (awIdx_ff == video_front_pkg::IDX_SYNC_CTRL)
        syncCtrl_ff <= wData_ff[7:0];
      else if (awIdx_ff == video_front_pkg::IDX_LOOP_GAIN)
        gain_ff <= wData_ff[7:0];
      else if (awIdx_ff == video_front_pkg::IDX_HSOUT_CTRL)
        hsCtrl_ff <= wData_ff[7:0];
    end
  end

  // read channel, one cycle after the address is taken
  logic [7:0] rdByte;
  logic       rdHit;
  logic [7:0] arIdx;
  assign arIdx = idx_of(s_axi_araddr);

  always_comb begin
    rdHit  = 1'b1;
    rdByte = 8'h00;
    if (arIdx == video_front_pkg::IDX_INPUT_CFG) rdByte = inputCfg_ff;
    else if (arIdx == video_front_pkg::IDX_CLAMP_START_H) rdByte = startHi_ff;
    else if (arIdx == video_front_pkg::IDX_CLAMP_START_L) rdByte = startLo_ff;
    else if (arIdx == video_front_pkg::IDX_CLAMP_WIDTH) rdByte = width_ff;
    else if (arIdx == video_front_pkg::IDX_OUT_FORMAT) rdByte = outFmt_ff;
    else if (arIdx == video_front_pkg::IDX_SLICER_A) rdByte = slicerA_ff;
    else if (arIdx == video_front_pkg::IDX_SLICER_B) rdByte = slicerB_ff;
    else if (arIdx == video_front_pkg::IDX_SYNC_CTRL) rdByte = syncCtrl_ff;
    else if (arIdx == video_front_pkg::IDX_LOOP_GAIN) rdByte = gain_ff;
    else if (arIdx == video_front_pkg::IDX_HSOUT_CTRL) rdByte = hsCtrl_ff;
    else if (arIdx == video_front_pkg::IDX_SYNC_STATUS)
      rdByte = {3'b000, triLevelSeen, clampOn, act_ff};
    else rdHit = 1'b0;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= video_front_pkg::RESP_OKAY;
    end else if (clkEn) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rdByte};
        s_axi_rresp  <= rdHit ? video_front_pkg::RESP_OKAY
                              : video_front_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // copy-protection mask and sync paths
  logic maskActive, greenSyncMasked;
  // only the flagged pulse window is removed; normal sync still passes
  assign maskActive = copyProtDetect && copyMaskIn;
  assign greenSyncMasked = greenSliceIn && !maskActive;

  logic hsPrev_ff;
  logic hsTrail;
  assign hsTrail = hsPrev_ff && !hsyncIn;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      loopSyncOut <= 1'b0;
      hsyncOut    <= 1'b0;
      hsPrev_ff   <= 1'b0;
    end else if (clkEn) begin
      hsPrev_ff   <= hsyncIn;
      loopSyncOut <= greenSyncMasked;
      hsyncOut    <= hsCtrl_ff[video_front_pkg::HSOUT_MASK_DIS] ? hsyncIn
                     : (hsyncIn && !maskActive);
    end
  end

  // activity detect: edge seen within a window per source
  logic [15:0] actCnt_ff;
  video_front_pkg::sync_act_s seen_ff;
  logic vsPrev_ff, gPrev_ff;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      actCnt_ff <= 16'h0000;
      seen_ff   <= '0;
      act_ff    <= '0;
      vsPrev_ff <= 1'b0;
      gPrev_ff  <= 1'b0;
    end else if (clkEn) begin
      vsPrev_ff <= vsyncIn;
      gPrev_ff  <= greenSliceIn;
      if (actCnt_ff == 16'(ACT_WINDOW - 1)) begin
        actCnt_ff <= 16'h0000;
        act_ff    <= seen_ff;
        seen_ff   <= '0;
      end else begin
        actCnt_ff <= actCnt_ff + 16'h0001;
        if (hsTrail && (vsyncIn != vsPrev_ff)) seen_ff.hsSep <= 1'b1;
        if (hsTrail && !vsyncIn) seen_ff.csOnHs <= 1'b1;
        if (greenSliceIn != gPrev_ff) seen_ff.csGreen <= 1'b1;
      end
    end
  end

  // clamp timing from trailing hsync edge
  logic [CNT_W-1:0] pixCnt_ff;
  logic [CNT_W-1:0] startPix;
  logic [7:0]       widthCnt_ff;
  logic             coastLine_ff;
  assign startPix = CNT_W'({startHi_ff, startLo_ff});

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pixCnt_ff    <= '0;
      widthCnt_ff  <= 8'h00;
      coastLine_ff <= 1'b0;
      clampOn      <= 1'b0;
      blackAvgStart <= 1'b0;
    end else if (clkEn) begin
      blackAvgStart <= 1'b0;
      if (hsTrail) begin
        pixCnt_ff    <= '0;
        coastLine_ff <= loopCoasting;
        clampOn      <= 1'b0;
      end else begin
        if (pixCnt_ff != '1) pixCnt_ff <= pixCnt_ff + 1'b1;
        if (loopCoasting) coastLine_ff <= 1'b1;
        if (pixCnt_ff == startPix) begin
          blackAvgStart <= 1'b1;
          if (!inputCfg_ff[video_front_pkg::CFG_DC_COUPLE_BIT] &&
              (syncCtrl_ff[video_front_pkg::SYNC_COAST_CLAMP] ||
               !(coastLine_ff || loopCoasting)) && width_ff != 8'h00) begin
            clampOn     <= 1'b1;
            widthCnt_ff <= width_ff;
          end
        end else if (clampOn) begin
          if (widthCnt_ff == 8'h01) clampOn <= 1'b0;
          widthCnt_ff <= widthCnt_ff - 8'h01;
        end
      end
    end
  end

  // tri-level detect from digitized green: sample swings above mid during sync
  always_ff @(posedge ref_clk) begin
    if (rst) triLevelSeen <= 1'b0;
    else if (clkEn && pixValid && hsyncIn) begin
      if (pixIn.green > video_front_pkg::CHROMA_MID) triLevelSeen <= 1'b1;
    end else if (clkEn && vsyncIn) triLevelSeen <= 1'b0;
  end

  // format path, no colour conversion
  logic phase_ff;
  logic [7:0] vHold_ff;
  logic comp;
  assign comp = inputCfg_ff[video_front_pkg::CFG_COMPONENT_BIT];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pixOut      <= '0;
      pixOutValid <= 1'b0;
      phase_ff    <= 1'b0;
      vHold_ff    <= 8'h00;
      dcCoupled   <= 1'b0;
      loopGain    <= video_front_pkg::RST_LOOP_GAIN;
      slicerThreshold <= 4'h0;
      slicerCtrlB <= 8'h00;
    end else if (clkEn) begin
      dcCoupled <= inputCfg_ff[video_front_pkg::CFG_DC_COUPLE_BIT];
      loopGain  <= gain_ff;
      slicerThreshold <= slicerA_ff[video_front_pkg::SLICER_THR_LSB +:
                                    video_front_pkg::SLICER_THR_W];
      slicerCtrlB <= slicerB_ff;
      pixOutValid <= pixValid;
      if (hsTrail) phase_ff <= 1'b0;
      if (pixValid) begin
        pixOut.green <= pixIn.green;
        if (comp && outFmt_ff[video_front_pkg::FMT_422_BIT]) begin
          pixOut.blue <= 8'h00;
          // odd slots repeat the even sample's red so u and v stay co-sited
          pixOut.red  <= phase_ff ? vHold_ff : pixIn.blue;
          phase_ff    <= !phase_ff;
          if (!phase_ff) vHold_ff <= pixIn.red;
        end else begin
          // in component mode the offsets hold chroma black at midscale
          pixOut.blue <= pixIn.blue;
          pixOut.red  <= pixIn.red;
        end
      end
    end
  end

  // assertions
  a_gain_reset: assert property (@(posedge ref_clk)
    $fell(rst) |-> loopGain == video_front_pkg::RST_LOOP_GAIN)
    else $error("loop gain not at default after reset");
  a_clamp_dc_off: assert property (@(posedge ref_clk) disable iff (rst)
    dcCoupled && $past(dcCoupled) && $past(dcCoupled, 2) |-> !$rose(clampOn))
    else $error("clamp started while dc coupled");
  a_clamp_start: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(clampOn) |-> blackAvgStart)
    else $error("clamp start not at start pixel");
  a_hsout_mask: assert property (@(posedge ref_clk) disable iff (rst)
    clkEn && maskActive && !hsCtrl_ff[video_front_pkg::HSOUT_MASK_DIS]
    |=> !hsyncOut || !clkEn)
    else $error("hsync out not masked");
  a_loop_mask: assert property (@(posedge ref_clk) disable iff (rst)
    clkEn && maskActive |=> !loopSyncOut || !clkEn)
    else $error("loop sync not masked");
  a_blue_low: assert property (@(posedge ref_clk) disable iff (rst)
    clkEn && pixValid && comp &&
    outFmt_ff[video_front_pkg::FMT_422_BIT] |=> pixOut.blue == 8'h00)
    else $error("blue not low in 4:2:2");
  a_green_pass: assert property (@(posedge ref_clk) disable iff (rst)
    clkEn && pixValid |=> pixOut.green == $past(pixIn.green))
    else $error("green sample not passed");
  a_count_reset: assert property (@(posedge ref_clk) disable iff (rst)
    clkEn && hsTrail |=> pixCnt_ff == '0)
    else $error("pixel count not reset at hsync");
endmodule : video_clamp_format_sync_mask
`default_nettype wire

/* pkg/video_front_pkg.sv */
// video_front_pkg: register map, field positions and carrier types for the
// video input path control block.
// assumes: 32-bit axi4-lite access, one register per aligned word.
package video_front_pkg;
  // register indexes: the byte address is four times the index
  localparam logic [7:0] IDX_INPUT_CFG     = 8'h10;
  localparam logic [7:0] IDX_CLAMP_START_H = 8'h24;
  localparam logic [7:0] IDX_CLAMP_START_L = 8'h25;
  localparam logic [7:0] IDX_CLAMP_WIDTH   = 8'h26;
  localparam logic [7:0] IDX_OUT_FORMAT    = 8'h28;
  localparam logic [7:0] IDX_SLICER_A      = 8'h30;
  localparam logic [7:0] IDX_SLICER_B      = 8'h31;
  localparam logic [7:0] IDX_SYNC_CTRL     = 8'h60;
  localparam logic [7:0] IDX_LOOP_GAIN     = 8'h74;
  localparam logic [7:0] IDX_HSOUT_CTRL    = 8'h7a;
  localparam logic [7:0] IDX_SYNC_STATUS   = 8'h7c;

  localparam int CFG_COMPONENT_BIT = 4;
  localparam int CFG_DC_COUPLE_BIT = 3;
  localparam int FMT_422_BIT       = 0;
  localparam int SYNC_COAST_CLAMP  = 2;
  localparam int HSOUT_MASK_DIS    = 4;
  localparam int SLICER_THR_LSB    = 0;
  localparam int SLICER_THR_W      = 4;

  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] RST_LOOP_GAIN  = 8'h49;
  localparam logic [7:0] GAIN_HEADSWITCH = 8'h4c;
  localparam logic [7:0] CHROMA_MID     = 8'h80;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } pixel_s;

  typedef struct packed {
    logic hsSep;
    logic csOnHs;
    logic csGreen;
  } sync_act_s;
endpackage : video_front_pkg

/* verification/video_sink_model.sv */
// video_sink_model: downstream pixel consumer of the video control block.
// assumes: one sample per ref_clk edge, no back-pressure on the stream.
`timescale 1ns/1ps
`default_nettype none
module video_sink_model (
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  // stream from the block
  input  wire video_front_pkg::pixel_s pixOut,
  input  wire logic                    pixOutValid,
  input  wire logic                    clampOn,
  // tallies for the bench
  output var int                       nPix,
  output var int                       clampCycles,
  output video_front_pkg::pixel_s      lastPix
);
  // a pure sink: it takes every qualified sample, so no stall exists here
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      nPix        <= 0;
      clampCycles <= 0;
      lastPix     <= '0;
    end else begin
      if (pixOutValid) begin
        nPix    <= nPix + 1;
        lastPix <= pixOut;
      end
      if (clampOn) begin
        clampCycles <= clampCycles + 1;
      end
    end
  end
endmodule : video_sink_model
`default_nettype wire

/* verification/testbench.sv */
// testbench: register, format, clamp and sync mask checks of the block.
// assumes: axi4-lite master tasks, sink model at the pixel output.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [1:0] OK = video_front_pkg::RESP_OKAY;
  localparam logic [1:0] ER = video_front_pkg::RESP_SLVERR;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        clkEn = 1'b1;
  logic [9:0]  s_axi_awaddr = '0;
  logic [9:0]  s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        pixValid = 1'b0, hsyncIn = 1'b0, vsyncIn = 1'b0;
  logic        greenSliceIn = 1'b0, loopCoasting = 1'b0;
  logic        copyProtDetect = 1'b0, copyMaskIn = 1'b0;
  logic        pixOutValid, clampOn, blackAvgStart, dcCoupled;
  logic        loopSyncOut, hsyncOut, triLevelSeen;
  logic [7:0]  loopGain, slicerCtrlB;
  logic [3:0]  slicerThreshold;
  video_front_pkg::pixel_s pixIn = '0;
  video_front_pkg::pixel_s pixOut;
  video_front_pkg::pixel_s lastPix;
  int          n_mismatch = 0, tests_run = 0, nPix, clampCycles;
  int          r1, r2, a, c;

  video_clamp_format_sync_mask #(.ACT_WINDOW(64)) i_video_clamp_format_sync_mask (
    .ref_clk, .rst, .clkEn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pixIn, .pixValid, .hsyncIn, .vsyncIn, .greenSliceIn, .loopCoasting,
    .copyProtDetect, .copyMaskIn, .pixOut, .pixOutValid, .clampOn,
    .blackAvgStart, .dcCoupled, .loopSyncOut, .hsyncOut, .loopGain,
    .slicerThreshold, .slicerCtrlB, .triLevelSeen);
  video_sink_model i_video_sink_model (
    .ref_clk, .rst, .pixOut, .pixOutValid, .clampOn, .nPix, .clampCycles,
    .lastPix);

  always #2 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic regWr(input logic [7:0] idx, input logic [7:0] dat,
                       input logic [1:0] resp);
    @(posedge ref_clk);
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_wdata   <= {24'h0, dat};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!s_axi_bvalid) begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    chk({30'h0, s_axi_bresp}, {30'h0, resp});
    s_axi_bready <= 1'b0;
  endtask : regWr

  task automatic regRd(input logic [7:0] idx, input logic [7:0] exp,
                       input logic [1:0] resp);
    @(posedge ref_clk);
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!s_axi_rvalid) begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    chk(s_axi_rdata, {24'h0, exp});
    chk({30'h0, s_axi_rresp}, {30'h0, resp});
    s_axi_rready <= 1'b0;
  endtask : regRd

  // the falling hsync edge defines pixel zero of the line
  task automatic pulseHs;
    @(posedge ref_clk);
    hsyncIn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    hsyncIn <= 1'b0;
  endtask : pulseHs

  task automatic pixRun(input logic dec);
    video_front_pkg::pixel_s ex;
    int base;
    logic [7:0] k;
    pulseHs();
    base = nPix;
    for (int i = 0; i <= 4; i++) begin
      @(posedge ref_clk);
      pixIn    <= {8'h10 + 8'(i), 8'h40 + 8'(i), 8'h70 + 8'(i)};
      pixValid <= (i < 4);
      @(negedge ref_clk);
      if (i > 0) begin
        k  = 8'(i - 1);
        ex = {8'h10 + k, 8'h40 + k, 8'h70 + k};
        if (dec) ex = {k[0] ? 8'h0f + k : 8'h70 + k, 8'h40 + k, 8'h00};
        chk({8'h0, pixOut}, {8'h0, ex});
        chk({31'h0, pixOutValid}, 32'h1);
      end
    end
    repeat (2) @(negedge ref_clk);
    chk(32'(nPix - base), 32'd4);
    chk({8'h0, lastPix}, {8'h0, ex});
  endtask : pixRun

  // times are counted in cycles after the falling hsync edge
  task automatic lineRun(input logic coast, output int rise, output int avg,
                         output int cl);
    int c0;
    loopCoasting <= coast;
    rise = -1;
    avg  = -2;
    c0   = clampCycles;
    pulseHs();
    for (int t = 1; t <= 400; t++) begin
      @(negedge ref_clk);
      if (clampOn && rise < 0) rise = t;
      if (blackAvgStart) avg = t;
    end
    cl = clampCycles - c0;
  endtask : lineRun

  task automatic results;
    $display("checks run %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  initial begin
    #100000;
    n_mismatch++;
    results();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    regRd(8'h74, 8'h49, OK);
    chk({24'h0, loopGain}, 32'h49);
    regRd(8'h10, 8'h00, OK);
    regRd(8'h00, 8'h00, ER);
    regWr(8'h01, 8'h55, ER);
    regWr(8'h74, 8'h4c, OK);
    regRd(8'h74, 8'h4c, OK);
    chk({24'h0, loopGain}, 32'h4c);
    regWr(8'h30, 8'h0b, OK);
    regWr(8'h31, 8'h5a, OK);
    repeat (2) @(negedge ref_clk);
    chk({28'h0, slicerThreshold}, 32'hb);
    chk({24'h0, slicerCtrlB}, 32'h5a);
    pixRun(1'b0);
    regWr(8'h10, 8'h10, OK);
    pixRun(1'b0);
    regWr(8'h28, 8'h01, OK);
    pixRun(1'b1);
    // start above 0x30 so green-embedded sync checks stay valid
    regWr(8'h25, 8'h31, OK);
    regWr(8'h26, 8'h04, OK);
    lineRun(1'b0, r1, a, c);
    chk(32'(c), 32'd4);
    chk(32'(a), 32'(r1));
    // late start lands the clamp past active pixels
    regWr(8'h24, 8'h01, OK);
    regWr(8'h25, 8'h20, OK);
    regRd(8'h24, 8'h01, OK);
    lineRun(1'b0, r2, a, c);
    chk(32'(r2 - r1), 32'd239);
    chk(32'(c), 32'd4);
    chk(32'(a), 32'(r2));
    @(posedge ref_clk);
    s_axi_wstrb <= 4'h0;
    regWr(8'h26, 8'hff, OK);
    s_axi_wstrb <= 4'hf;
    regRd(8'h26, 8'h04, OK);
    lineRun(1'b1, r1, a, c);
    chk(32'(c), 32'd0);
    regWr(8'h60, 8'h04, OK);
    lineRun(1'b1, r1, a, c);
    chk(32'(c), 32'd4);
    regWr(8'h10, 8'h18, OK);
    lineRun(1'b0, r1, a, c);
    chk(32'(c), 32'd0);
    chk({31'h0, dcCoupled}, 32'h1);
    @(posedge ref_clk);
    hsyncIn        <= 1'b1;
    copyProtDetect <= 1'b1;
    copyMaskIn     <= 1'b1;
    greenSliceIn   <= 1'b1;
    repeat (4) @(negedge ref_clk);
    chk({31'h0, hsyncOut}, 32'h0);
    chk({31'h0, loopSyncOut}, 32'h0);
    // outside the mask window sync passes although detection is on
    @(posedge ref_clk);
    copyMaskIn <= 1'b0;
    repeat (2) @(negedge ref_clk);
    chk({31'h0, hsyncOut}, 32'h1);
    chk({31'h0, loopSyncOut}, 32'h1);
    @(posedge ref_clk);
    copyMaskIn <= 1'b1;
    regWr(8'h7a, 8'h10, OK);
    repeat (4) @(negedge ref_clk);
    chk({31'h0, hsyncOut}, 32'h1);
    // tri-level: a digitized green sample above mid while in sync
    chk({31'h0, triLevelSeen}, 32'h0);
    @(posedge ref_clk);
    pixIn    <= {8'h00, 8'hc0, 8'h00};
    pixValid <= 1'b1;
    @(posedge ref_clk);
    pixValid <= 1'b0;
    vsyncIn  <= 1'b1;
    @(negedge ref_clk);
    chk({31'h0, triLevelSeen}, 32'h1);
    @(posedge ref_clk);
    vsyncIn <= 1'b0;
    @(negedge ref_clk);
    chk({31'h0, triLevelSeen}, 32'h0);
    // green slicer activity spans more than two windows; hsync stays flat
    for (int i = 0; i < 140; i++) begin
      @(posedge ref_clk);
      greenSliceIn <= !greenSliceIn;
    end
    regRd(8'h7c, 8'h01, OK);
    // clock enable low freezes the registered sync output
    clkEn   <= 1'b0;
    hsyncIn <= 1'b0;
    repeat (3) @(negedge ref_clk);
    chk({31'h0, hsyncOut}, 32'h1);
    @(posedge ref_clk);
    clkEn <= 1'b1;
    repeat (2) @(negedge ref_clk);
    chk({31'h0, hsyncOut}, 32'h0);
    results();
  end
endmodule : testbench
`default_nettype wire
